/* hdl/tapo_top.v */
// Digital side of a triple pipelined converter: phases, alignment,
// correction, double latching and output coding for three channels.
// Assumes stage codes come from comparators latched by our own phases
// (same clock domain) and the format select pin is asynchronous.
`include "tapo_consts.vh"
`default_nettype none

module tapo_channel #(
    parameter integer STAGES = `TAPO_NUM_STAGES,
    parameter integer WORD_W = `TAPO_WORD_W
) (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   reset,
    // Phase strobes from the shared phase generator
    input  wire                   sampStb,
    input  wire                   holdStb,
    // Stage results, stage 0 in the low bits
    input  wire [2*STAGES-1:0]    stageCodes,
    // Coding select, already synchronised
    input  wire                   fmtTwos,
    // Output word
    output reg  [WORD_W-1:0]      word_ff
);
    wire [2*STAGES-1:0] alignedCodes;     // Tails of all delay chains
    reg  [WORD_W-1:0]   latchA_ff;        // First output latch stage
    reg  [`TAPO_SUM_W-1:0] sum;           // Corrected sum
    reg  [WORD_W-1:0]   clipped;          // Sum clipped to the word range
    integer             k;                // Stage index in the adder

    genvar m;
    generate
        for (m = 0; m < STAGES; m = m + 1) begin : gStage
            // Chain length so every stage reaches the end together
            localparam integer LEN = `TAPO_ALIGN_DEPTH - ((m + 1) / 2);
            reg [1:0]         cap_ff;     // Code caught at its own phase
            reg [2*LEN-1:0]   chain_ff;   // Delay line on sampling strobes
            // Even stages resolve in holding phase, odd in sampling phase
            wire capStb = (m % 2 == 0) ? holdStb : sampStb;
            // Catch the stage code at the end of its active phase
            always @(posedge core_clk) begin
                if (reset) begin
                    cap_ff <= 2'h0;
                end else if (capStb) begin
                    cap_ff <= stageCodes[2*m +: 2];
                end
            end
            // Shift the delay line on the internal sampling strobe
            if (LEN > 1) begin : gLong
                // Longer chains move two bits along per strobe
                always @(posedge core_clk) begin
                    if (reset) begin
                        chain_ff <= {(2*LEN){1'b0}};
                    end else if (sampStb) begin
                        chain_ff <= {chain_ff[2*LEN-3:0], cap_ff};
                    end
                end
            end else begin : gShort
                // A single slot simply follows the catch register
                always @(posedge core_clk) begin
                    if (reset) begin
                        chain_ff <= {(2*LEN){1'b0}};
                    end else if (sampStb) begin
                        chain_ff <= cap_ff;
                    end
                end
            end
            assign alignedCodes[2*m +: 2] = chain_ff[2*LEN-1 -: 2];
        end
    endgenerate

    // Overlapping add: each redundant stage weighs one bit less than the last
    always @* begin
        sum = {`TAPO_SUM_W{1'b0}};
        for (k = 0; k < STAGES; k = k + 1) begin
            sum = sum + ({{(`TAPO_SUM_W-2){1'b0}}, alignedCodes[2*k +: 2]}
                  << (STAGES - 1 - k));
        end
        // Over-range from redundancy saturates at full scale
        if (sum > `TAPO_WORD_MAX) begin
            clipped = {WORD_W{1'b1}};
        end else begin
            clipped = sum[WORD_W-1:0];
        end
    end

    // Double latching: holding strobe then next sampling strobe
    always @(posedge core_clk) begin
        if (reset) begin
            latchA_ff <= {WORD_W{1'b0}};
            word_ff   <= {WORD_W{1'b0}};
        end else begin
            // First stage catches the corrected word while the chains stand still
            if (holdStb) begin
                latchA_ff <= clipped;
            end
            // Second stage updates the bus once per sample cycle
            if (sampStb) begin
                // Two's complement is offset binary with the top bit flipped
                word_ff <= {latchA_ff[WORD_W-1] ^ fmtTwos,
                            latchA_ff[WORD_W-2:0]};
            end
        end
    end
endmodule

module tapo_top #(
    parameter integer WORD_W  = `TAPO_WORD_W,
    parameter integer STAGES  = `TAPO_NUM_STAGES,
    parameter integer INVALID = `TAPO_INVALID_CYC
) (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   reset,
    // Static coding select pin: low offset binary, high two's complement
    input  wire                   format_select,
    // Stage results of the three channels
    input  wire [2*STAGES-1:0]    redStageCodes,
    input  wire [2*STAGES-1:0]    grnStageCodes,
    input  wire [2*STAGES-1:0]    bluStageCodes,
    // Phase outputs to the switched-capacitor front ends
    output reg                    sampPhase_ff,
    output reg                    holdPhase_ff,
    // Output words
    output wire [WORD_W-1:0]      redWord_ff,
    output wire [WORD_W-1:0]      grnWord_ff,
    output wire [WORD_W-1:0]      bluWord_ff,
    // Word status
    output reg                    wordStb_ff,
    output reg                    dataValid_ff
);
    reg  [1:0]  phaseCnt_ff;          // Position in the sample clock cycle
    reg  [1:0]  nxt_phaseCnt;         // Next phase position
    reg         fmtMeta_ff;           // Select pin, first synchroniser stage
    reg         fmtSync_ff;           // Select pin, second synchroniser stage
    reg  [4:0]  warmCnt_ff;           // Sample cycles since reset
    wire        sampStb;              // Last core cycle of the sampling phase
    wire        holdStb;              // Last core cycle of the holding phase

    // Strobes mark the falling edge of each phase
    assign sampStb = (phaseCnt_ff == `TAPO_PH_SAMP);
    assign holdStb = (phaseCnt_ff == `TAPO_PH_HOLD);

    // Phase counter wraps once per sample clock cycle
    always @* begin
        nxt_phaseCnt = phaseCnt_ff + 2'h1;
    end

    // Sampling and holding phases separated by a gap cycle each
    always @(posedge core_clk) begin
        if (reset) begin
            // Start one step before sampling so the first strobe follows release
            phaseCnt_ff  <= `TAPO_PH_GAP2;
            sampPhase_ff <= 1'b0;
            holdPhase_ff <= 1'b0;
        end else begin
            phaseCnt_ff  <= nxt_phaseCnt;
            sampPhase_ff <= (nxt_phaseCnt == `TAPO_PH_SAMP);
            holdPhase_ff <= (nxt_phaseCnt == `TAPO_PH_HOLD);
        end
    end

    // Format select pin passes two flops
    always @(posedge core_clk) begin
        if (reset) begin
            fmtMeta_ff <= 1'b0;
            fmtSync_ff <= 1'b0;
        end else begin
            fmtMeta_ff <= format_select;
            fmtSync_ff <= fmtMeta_ff;
        end
    end

    // Warm-up count; words are flagged invalid until it expires
    always @(posedge core_clk) begin
        if (reset) begin
            warmCnt_ff   <= 5'h00;
            dataValid_ff <= 1'b0;
            wordStb_ff   <= 1'b0;
        end else begin
            wordStb_ff <= sampStb;
            // Count stops at the limit so the flag can never fall again
            if (sampStb && (warmCnt_ff != INVALID[4:0])) begin
                warmCnt_ff <= warmCnt_ff + 5'h01;
            end
            if (sampStb && (warmCnt_ff == INVALID[4:0] - 5'h01)) begin
                dataValid_ff <= 1'b1;
            end
        end
    end

    // Three identical channels on the same strobes
    tapo_channel #(.STAGES(STAGES), .WORD_W(WORD_W)) uRed (
        .core_clk   (core_clk),
        .reset      (reset),
        .sampStb    (sampStb),
        .holdStb    (holdStb),
        .stageCodes (redStageCodes),
        .fmtTwos    (fmtSync_ff),
        .word_ff    (redWord_ff)
    );
    tapo_channel #(.STAGES(STAGES), .WORD_W(WORD_W)) uGrn (
        .core_clk   (core_clk),
        .reset      (reset),
        .sampStb    (sampStb),
        .holdStb    (holdStb),
        .stageCodes (grnStageCodes),
        .fmtTwos    (fmtSync_ff),
        .word_ff    (grnWord_ff)
    );
    tapo_channel #(.STAGES(STAGES), .WORD_W(WORD_W)) uBlu (
        .core_clk   (core_clk),
        .reset      (reset),
        .sampStb    (sampStb),
        .holdStb    (holdStb),
        .stageCodes (bluStageCodes),
        .fmtTwos    (fmtSync_ff),
        .word_ff    (bluWord_ff)
    );
    // Latency of five sample cycles follows from the chain lengths
    // plus the two latch stages.
endmodule

`default_nettype wire

/* hdl/tapo_consts.vh */
// Constants for the triple pipelined converter output logic.
// Assumes one core clock, of which the sample clock is a fixed division.
`ifndef TAPO_CONSTS_VH
`define TAPO_CONSTS_VH

`define TAPO_WORD_W        8       // Output word width
`define TAPO_NUM_STAGES    7       // Six redundant stages plus final flash
`define TAPO_CODE_W        2       // Bits per stage result
`define TAPO_ALIGN_DEPTH   4       // Sample strobes from stage 0 to alignment
`define TAPO_SUM_W         10      // Width of the correction sum
`define TAPO_WORD_MAX      10'h0ff // Largest output code
`define TAPO_PHASE_DIV     4       // Core cycles per sample clock cycle
`define TAPO_PH_SAMP       2'h0    // Phase count: sampling phase
`define TAPO_PH_GAP1       2'h1    // Phase count: gap after sampling
`define TAPO_PH_HOLD       2'h2    // Phase count: holding phase
`define TAPO_PH_GAP2       2'h3    // Phase count: gap after holding
`define TAPO_INVALID_CYC   20      // Sample cycles of invalid data at start
`define TAPO_LATENCY_CYC   5       // Output latency in sample cycles

`endif

/* tb/tapo_properties.sv */
// Checker for phases, word cadence, latency and the valid flag.
// Assumes it is bound into tapo_top on the single core clock.
`default_nettype none
module tapo_props #(
    parameter integer INVALID = 20
) (
    // Clock, reset and stimulus
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [13:0] redStageCodes,
    // Observed outputs
    input wire logic        sampPhase_ff,
    input wire logic        holdPhase_ff,
    input wire logic [7:0]  redWord_ff,
    input wire logic        wordStb_ff,
    input wire logic        dataValid_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [5:0] age_ff;  // Cycles since release, saturating
    logic [5:0] nStb_ff; // Strobes since release, saturating
    // Low seven bits of a clipped correction sum
    function automatic logic [6:0] low7(input logic [9:0] s);
        return (s > 10'h0ff) ? 7'h7f : s[6:0];
    endfunction
    // Count time and sampling strobes after release
    always_ff @(posedge core_clk) begin
        if (reset) begin
            age_ff  <= 6'h00;
            nStb_ff <= 6'h00;
        end else begin
            if (age_ff != 6'h3f) age_ff <= age_ff + 6'h01;
            if (sampPhase_ff && nStb_ff != 6'h3f) nStb_ff <= nStb_ff + 6'h01;
        end
    end
    phase_nonovl_a: assert property (!(sampPhase_ff && holdPhase_ff))
        else $error("phases overlap");
    hold_follows_a: assert property (sampPhase_ff |-> ##2 holdPhase_ff)
        else $error("hold phase not two cycles after sampling");
    samp_period_a: assert property (sampPhase_ff |=> !sampPhase_ff [*3] ##1 sampPhase_ff)
        else $error("sampling phase period wrong");
    word_cadence_a: assert property (wordStb_ff |-> ##4 wordStb_ff)
        else $error("word strobe not every sample cycle");
    word_hold_a: assert property (!wordStb_ff |-> $stable(redWord_ff))
        else $error("word changed without strobe");
    stb_after_samp_a: assert property (wordStb_ff |-> $past(sampPhase_ff))
        else $error("word not loaded at end of sampling cycle");
    valid_rise_a: assert property ($rose(dataValid_ff) |->
        nStb_ff >= INVALID && nStb_ff <= INVALID + 1)
        else $error("valid flag rose at wrong count");
    valid_stays_a: assert property (dataValid_ff |=> dataValid_ff)
        else $error("valid flag dropped");
    // Low bits follow the stage codes presented 19 down to 7 cycles earlier
    red_latency_a: assert property (wordStb_ff && age_ff > 6'h18 |->
        redWord_ff[6:0] == low7((10'($past(redStageCodes[1:0], 19)) << 6)
        + (10'($past(redStageCodes[3:2], 17)) << 5) + (10'($past(redStageCodes[5:4], 15)) << 4)
        + (10'($past(redStageCodes[7:6], 13)) << 3) + (10'($past(redStageCodes[9:8], 11)) << 2)
        + (10'($past(redStageCodes[11:10], 9)) << 1) + 10'($past(redStageCodes[13:12], 7))))
        else $error("red word not matching codes");
endmodule
bind tapo_top tapo_props #(.INVALID(INVALID)) i_tapo_props (.core_clk, .reset,
    .redStageCodes, .sampPhase_ff, .holdPhase_ff, .redWord_ff, .wordStb_ff, .dataValid_ff);
`default_nettype wire

/* tb/tapo_capture.sv */
// Downstream capture of the three output words.
// Assumes words are settled in the strobe cycle.
`default_nettype none
module tapo_capture (
    // Clock
    input  wire logic        core_clk,
    // Words and status from the converter
    input  wire logic [23:0] words,
    input  wire logic        wordStb,
    input  wire logic        dataValid,
    // Captured words
    output var  logic [23:0] capWords_ff,
    output var  logic        capVld_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // Capture every strobed word; flag it valid only once the converter reports valid data
    always_ff @(posedge core_clk) begin
        capVld_ff <= wordStb && dataValid;
        if (wordStb) capWords_ff <= words;
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench: random stage codes in, expected words queued and compared.
// Assumes design and capture model share one clock.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;       // Core clock
    logic reset = 1'b1;          // Synchronous reset
    logic format_select = 1'b0;  // Output coding select
    logic fmtLag = 1'b0;         // Coding of the word last shown
    logic [41:0] stg = '0;       // Stage codes, red in low bits
    logic [41:0] hist [0:15];    // Codes driven in recent cycles
    logic [23:0] exp;            // Oldest expected word set
    logic [23:0] q [$];          // Expected word sets
    integer seed = 32'hed28364a; // Random seed
    int t = 0;                   // Cycles since release
    int num_checks = 0;          // Comparisons made
    int n_mismatch = 0;          // Comparisons failed
    wire logic sampPhase_ff, holdPhase_ff, wordStb_ff, dataValid_ff, capVld_ff;
    wire logic [7:0] redWord_ff, grnWord_ff, bluWord_ff;
    wire logic [23:0] capWords_ff;
    tapo_top #(.INVALID(3)) i_tapo_top (.core_clk, .reset, .format_select,
        .redStageCodes(stg[13:0]), .grnStageCodes(stg[27:14]), .bluStageCodes(stg[41:28]),
        .sampPhase_ff, .holdPhase_ff, .redWord_ff, .grnWord_ff, .bluWord_ff,
        .wordStb_ff, .dataValid_ff);
    tapo_capture i_tapo_capture (.core_clk, .words({redWord_ff, grnWord_ff, bluWord_ff}),
        .wordStb(wordStb_ff), .dataValid(dataValid_ff), .capWords_ff, .capVld_ff);
    always #5 core_clk = ~core_clk;
    // Clipped offset binary word of one channel for the sample held at cycle c
    function automatic logic [7:0] expw(input int c, input int ch);
        logic [9:0] s;
        s = '0;
        for (int m = 0; m < 7; m++)
            s += 10'(hist[(c - 12 + 2 * m) & 15][14 * ch + 2 * m +: 2]) << (6 - m);
        return (s > 10'h0ff) ? 8'hff : s[7:0];
    endfunction
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", name, want, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Stop at an edge that ends a strobe cycle, so coding changes land cleanly
    task automatic stbEdge();
        for (int k = 0; k < 9; k++) begin
            @(posedge core_clk);
            if (wordStb_ff === 1'b1) return;
        end
        n_mismatch++;
        end_sim();
    endtask
    // Drive random codes each cycle and note the words they must give
    always @(posedge core_clk) begin
        stg <= 42'({$random(seed), $random(seed)});
        if (reset) begin
            t <= 0;
            q.delete();
        end else begin
            t <= t + 1;
            hist[t[3:0]] = stg;
            if (holdPhase_ff === 1'b1 && t >= 14)
                q.push_back({expw(t, 0), expw(t, 1), expw(t, 2)});
        end
    end
    // Compare each captured word set with the oldest note
    always @(posedge core_clk) begin
        fmtLag <= format_select;
        if (capVld_ff === 1'b1 && t >= 22 && q.size() > 0) begin
            exp = q.pop_front() ^ {3{fmtLag, 7'h00}};
            check("words", capWords_ff, exp);
        end
    end
    // Warm-up, both codings, then a reset in mid-stream
    initial begin
        for (int r = 0; r < 2; r++) begin
            repeat (12) @(posedge core_clk);
            reset <= 1'b0;
            repeat (2) @(posedge core_clk);
            check("warm valid", 24'(dataValid_ff), 24'h0);
            repeat (100) @(posedge core_clk);
            check("valid", 24'(dataValid_ff), 24'h1);
            stbEdge();
            format_select <= 1'b1;
            repeat (100) @(posedge core_clk);
            check("pending", 24'(q.size() <= 2), 24'h1);
            $display("test run %0d done", r);
            stbEdge();
            format_select <= 1'b0;
            reset <= 1'b1;
        end
        end_sim();
    end
endmodule
`default_nettype wire
